// ==== pkg/lbc_pkg.sv ====
// Purpose: shared constants and types for the lamp blink-code controller
// Assumes: 125 MHz module clock, 1 ms timing base
// Notes: blink timings and register offsets are local choices
package lbc_pkg;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

  // lamp timings in ms ticks
  localparam logic [15:0] SHORT_ON_MS = 16'h0096;
  localparam logic [15:0] LONG_ON_MS = 16'h0258;
  localparam logic [15:0] OFF_MS = 16'h012c;
  localparam logic [15:0] MID_MS = 16'h03e8;
  localparam logic [15:0] GAP_MS = 16'h07d0;
  localparam logic [15:0] GREEN_HALF_MS = 16'h00fa;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_UPER = 8'h04;
  localparam logic [7:0] REG_LATCH = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [15:0] UPER_RST = 16'h01f4;
  localparam logic [15:0] LATCH_RST = 16'h03e8;

  localparam int NCH = 16;
  localparam int NFLT = 80;
  localparam int IDX_W = 7;
  localparam logic [2:0] KIND_MAX = 3'h5;
  localparam logic [IDX_W-1:0] IDX_LAST = 7'h4f;
  localparam logic [3:0] INT_ANA_CODE = 4'h4;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_OPER, MODE_VERIFY, MODE_DOWNLOAD, MODE_FAILSAFE,
    MODE_UPGRADE
  } lbc_mode_t;

  typedef enum logic [1:0] {
    I_IDLE = 2'b00, I_ON = 2'b01, I_OFF = 2'b11, I_GAP = 2'b10
  } lbc_int_st_t;

  typedef enum logic [2:0] {
    O_IDLE = 3'b000, O_SON = 3'b001, O_SOFF = 3'b011, O_MID = 3'b010,
    O_LON = 3'b110, O_LOFF = 3'b111, O_GAP = 3'b101
  } lbc_io_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } lbc_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [3:0] chan;
  } lbc_io_fault_t;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } lbc_int_fault_t;

  typedef struct packed {
    logic status;
    logic int_fault;
    logic io_fault;
    logic user;
  } lbc_lamps_t;
endpackage

// ==== rtl/lbc_lamp_ctrl.sv ====
// Purpose: drives status, internal fault, I/O fault and user lamps
// Assumes: inputs synchronous to clk_i, fault events are one-cycle pulses
// Notes: one latch timer, restarted by any I/O fault or analog diagnostic, not by internal faults
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module lbc_lamp_ctrl #(
  parameter int unsigned TICK_CYC = lbc_pkg::TICK_CYC
) (
  input logic clk_i,
  input logic rst_i,
  input lbc_pkg::lbc_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  input lbc_pkg::lbc_mode_t mode_i,
  input logic prog_loaded_i,
  input logic prog_run_i,
  input lbc_pkg::lbc_int_fault_t int_fault_i,
  input logic [lbc_pkg::NCH-1:0] ana_diag_i,
  input lbc_pkg::lbc_io_fault_t io_fault_i,
  input logic user_val_i,
  output lbc_pkg::lbc_lamps_t lamps_o,
  output logic [lbc_pkg::NCH-1:0] ana_lowlow_o
);
  import lbc_pkg::*;

  localparam int PW = $clog2(TICK_CYC + 1);

  function automatic logic [IDX_W-1:0] flt_idx(input logic [2:0] k,
                                               input logic [3:0] c);
    flt_idx = {k - 3'h1, c};
  endfunction

  function automatic logic [IDX_W-1:0] scan_next(input logic [IDX_W-1:0] s);
    scan_next = (s == IDX_LAST) ? '0 : s + 7'h01;
  endfunction

  logic [PW-1:0] pre_r;
  logic tick;
  logic user_en_r;
  logic [15:0] uper_r;
  logic [15:0] latch_ms_r;
  logic [31:0] rdata_r;
  logic [NFLT-1:0] lat_r;
  logic [NCH-1:0] ana_r;
  logic [15:0] lt_r;
  logic new_io;
  logic any_new;
  logic expire;
  logic [3:0] int_code_r;
  logic [3:0] eff_code;
  logic int_act;
  lbc_int_st_t ist_r;
  logic [15:0] itm_r;
  logic [3:0] icnt_r;
  logic [3:0] icode_r;
  logic int_lamp_r;
  lbc_io_st_t ost_r;
  logic [15:0] otm_r;
  logic [4:0] ocnt_r;
  logic [2:0] kind_r;
  logic [3:0] chan_r;
  logic [IDX_W-1:0] scan_r;
  logic io_any;
  logic io_lamp_r;
  logic [15:0] gtm_r;
  logic gph_r;
  logic green_r;
  logic [15:0] utm_r;
  logic uph_r;
  logic user_r;

  // 1 ms timing base
  assign tick = (pre_r == PW'(TICK_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_en_r <= CTRL_RST;
      uper_r <= UPER_RST;
      latch_ms_r <= LATCH_RST;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        REG_CTRL: user_en_r <= bus_i.wdata[0];
        REG_UPER: uper_r <= bus_i.wdata[15:0];
        REG_LATCH: latch_ms_r <= bus_i.wdata[15:0];
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i || !bus_i.rd) begin
      rdata_r <= '0;
    end else begin
      case (bus_i.addr)
        REG_CTRL: rdata_r <= {31'h0, user_en_r};
        REG_UPER: rdata_r <= {16'h0, uper_r};
        REG_LATCH: rdata_r <= {16'h0, latch_ms_r};
        REG_STAT: rdata_r <= {16'h0, chan_r, 1'b0, kind_r, eff_code,
                              1'b0, int_act, |ana_r, io_any};
        default: rdata_r <= '0;
      endcase
    end
  end
  assign rdata_o = rdata_r;

  assign new_io = io_fault_i.valid && io_fault_i.kind != 3'h0 &&
                  io_fault_i.kind <= KIND_MAX;
  assign any_new = new_io || (|ana_diag_i);
  // a fresh fault restarts the timer, so it never loses to the clear
  assign expire = !any_new && (lt_r == 16'h0 || (tick && lt_r == 16'h1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lt_r <= '0;
    end else if (any_new) begin
      lt_r <= latch_ms_r;
    end else if (tick && lt_r != 16'h0) begin
      lt_r <= lt_r - 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_r <= '0;
    end else begin
      if (expire) begin
        lat_r <= '0;
      end
      if (new_io) begin
        lat_r[flt_idx(io_fault_i.kind, io_fault_i.chan)] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || expire) begin
      ana_r <= '0;
    end else begin
      ana_r <= ana_r | ana_diag_i;
    end
  end
  assign ana_lowlow_o = ana_r;

  // latest internal code holds until power-off; shutdown is left only by restart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_code_r <= '0;
    end else if (int_fault_i.valid && int_fault_i.code != 4'h0) begin
      int_code_r <= int_fault_i.code;
    end else if (mode_i == MODE_OFF) begin
      int_code_r <= '0;
    end
  end

  assign eff_code = (ana_r != '0 && int_code_r == 4'h0) ? INT_ANA_CODE :
                    int_code_r;
  assign int_act = (mode_i == MODE_FAILSAFE || ana_r != '0) &&
                   eff_code != 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_r <= I_IDLE;
      itm_r <= '0;
      icnt_r <= '0;
      icode_r <= '0;
    end else begin
      if (tick && itm_r != 16'h0) begin
        itm_r <= itm_r - 16'h1;
      end
      if (!int_act) begin
        ist_r <= I_IDLE;
      end else begin
        case (ist_r)
          I_IDLE: begin
            ist_r <= I_ON;
            itm_r <= SHORT_ON_MS;
            icnt_r <= eff_code;
            icode_r <= eff_code;
          end
          I_ON: if (itm_r == 16'h0) begin
            ist_r <= I_OFF;
            itm_r <= OFF_MS;
            icnt_r <= icnt_r - 4'h1;
          end
          I_OFF: if (itm_r == 16'h0) begin
            if (icnt_r == 4'h0) begin
              ist_r <= I_GAP;
              itm_r <= GAP_MS;
            end else begin
              ist_r <= I_ON;
              itm_r <= SHORT_ON_MS;
            end
          end
          I_GAP: if (itm_r == 16'h0) begin
            ist_r <= I_IDLE;
          end
          default: ist_r <= I_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_lamp_r <= 1'b0;
    end else begin
      int_lamp_r <= (ist_r == I_ON);
    end
  end

  assign io_any = |lat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ost_r <= O_IDLE;
      otm_r <= '0;
      ocnt_r <= '0;
      kind_r <= '0;
      chan_r <= '0;
      scan_r <= '0;
    end else begin
      if (tick && otm_r != 16'h0) begin
        otm_r <= otm_r - 16'h1;
      end
      if (!io_any) begin
        ost_r <= O_IDLE;
      end else begin
        case (ost_r)
          O_IDLE: if (lat_r[scan_r]) begin
            kind_r <= scan_r[6:4] + 3'h1;
            chan_r <= scan_r[3:0];
            ocnt_r <= {2'b00, scan_r[6:4] + 3'h1};
            ost_r <= O_SON;
            otm_r <= SHORT_ON_MS;
          end else begin
            scan_r <= scan_next(scan_r);
          end
          O_SON: if (otm_r == 16'h0) begin
            ost_r <= O_SOFF;
            otm_r <= OFF_MS;
            ocnt_r <= ocnt_r - 5'h01;
          end
          O_SOFF: if (otm_r == 16'h0) begin
            if (ocnt_r == 5'h00) begin
              ost_r <= O_MID;
              otm_r <= MID_MS;
              ocnt_r <= {1'b0, chan_r} + 5'h01;
            end else begin
              ost_r <= O_SON;
              otm_r <= SHORT_ON_MS;
            end
          end
          O_MID: if (otm_r == 16'h0) begin
            ost_r <= O_LON;
            otm_r <= LONG_ON_MS;
          end
          O_LON: if (otm_r == 16'h0) begin
            ost_r <= O_LOFF;
            otm_r <= OFF_MS;
            ocnt_r <= ocnt_r - 5'h01;
          end
          O_LOFF: if (otm_r == 16'h0) begin
            if (ocnt_r == 5'h00) begin
              ost_r <= O_GAP;
              otm_r <= GAP_MS;
            end else begin
              ost_r <= O_LON;
              otm_r <= LONG_ON_MS;
            end
          end
          O_GAP: if (otm_r == 16'h0) begin
            ost_r <= O_IDLE;
            scan_r <= scan_next(scan_r);
          end
          default: ost_r <= O_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_lamp_r <= 1'b0;
    end else begin
      io_lamp_r <= (ost_r == O_SON || ost_r == O_LON);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gtm_r <= '0;
      gph_r <= 1'b0;
    end else if (tick) begin
      if (gtm_r >= GREEN_HALF_MS - 16'h1) begin
        gtm_r <= '0;
        gph_r <= ~gph_r;
      end else begin
        gtm_r <= gtm_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || mode_i == MODE_OFF) begin
      green_r <= 1'b0;
    end else if (mode_i == MODE_OPER && prog_loaded_i && prog_run_i) begin
      green_r <= 1'b1;
    end else begin
      green_r <= gph_r;
    end
  end

  // period below 2 ms means steady, a half period cannot be timed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      utm_r <= '0;
      uph_r <= 1'b0;
    end else if (tick) begin
      if (utm_r + 16'h1 >= {1'b0, uper_r[15:1]}) begin
        utm_r <= '0;
        uph_r <= ~uph_r;
      end else begin
        utm_r <= utm_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_r <= 1'b0;
    end else begin
      user_r <= user_en_r && user_val_i &&
                (uper_r[15:1] == 15'h0 || uph_r);
    end
  end

  assign lamps_o.status = green_r;
  assign lamps_o.int_fault = int_lamp_r;
  assign lamps_o.io_fault = io_lamp_r;
  assign lamps_o.user = user_r;

  // helper logic for the checks below
  lbc_io_st_t ost_q;
  lbc_int_st_t ist_q;
  logic [4:0] sh_r;
  logic [4:0] lg_r;
  logic [3:0] ib_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ost_q <= O_IDLE;
      ist_q <= I_IDLE;
      sh_r <= '0;
      lg_r <= '0;
      ib_r <= '0;
    end else begin
      ost_q <= ost_r;
      ist_q <= ist_r;
      sh_r <= (ost_r == O_IDLE) ? 5'h00 :
              (ost_r == O_SON && ost_q != O_SON) ? sh_r + 5'h01 : sh_r;
      lg_r <= (ost_r == O_IDLE) ? 5'h00 :
              (ost_r == O_LON && ost_q != O_LON) ? lg_r + 5'h01 : lg_r;
      ib_r <= (ist_r == I_IDLE) ? 4'h0 :
              (ist_r == I_ON && ist_q != I_ON) ? ib_r + 4'h1 : ib_r;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_GREEN_STEADY: assert property (
    mode_i == MODE_OPER && prog_loaded_i && prog_run_i |=> green_r)
    else $error("green not steady while running");
  AST_GREEN_FLASH: assert property (
    mode_i inside {MODE_VERIFY, MODE_DOWNLOAD, MODE_FAILSAFE} |=>
    green_r == $past(gph_r))
    else $error("green not flashing");
  AST_INT_START: assert property (
    int_act && ist_r == I_IDLE |=> ist_r == I_ON ##1 int_lamp_r)
    else $error("internal lamp did not start");
  AST_INT_BURST: assert property (
    ist_r == I_GAP && ist_q == I_OFF |-> ib_r == icode_r)
    else $error("internal burst count wrong");
  AST_INT_DARK: assert property (
    !int_act |-> ##2 !int_lamp_r)
    else $error("internal lamp lit without fault");
  AST_IO_SHORTS: assert property (
    ost_r == O_MID && ost_q == O_SOFF |-> sh_r == {2'b00, kind_r})
    else $error("short flash count wrong");
  AST_IO_LONGS: assert property (
    ost_r == O_GAP && ost_q == O_LOFF |-> lg_r == {1'b0, chan_r} + 5'h01)
    else $error("long flash count wrong");
  AST_IO_PAUSE: assert property (
    ost_r == O_LON && ost_q != O_LON |-> ost_q inside {O_MID, O_LOFF})
    else $error("long run without pause");
  AST_IO_DARK: assert property (
    !io_any |-> ##2 !io_lamp_r)
    else $error("io lamp lit without fault");
  AST_LATCH_SET: assert property (
    new_io |=> lat_r[flt_idx($past(io_fault_i.kind), $past(io_fault_i.chan))])
    else $error("fault not latched");
  AST_ANA_FORCE: assert property (
    ana_diag_i != '0 |=> (ana_lowlow_o & $past(ana_diag_i)) ==
    $past(ana_diag_i) && int_act)
    else $error("analog diag not forced");
  AST_USER_OFF: assert property (
    !user_en_r || !user_val_i |=> !user_r)
    else $error("user lamp lit while off");
  AST_IO_NEXT: assert property (
    ost_r == O_GAP && otm_r == 16'h0 && io_any |=>
    scan_r == scan_next($past(scan_r)))
    else $error("display did not advance");

  COV_IO_CODE: cover property (ost_r == O_GAP && ost_q == O_LOFF);
  COV_INT_CODE: cover property (ist_r == I_GAP && ist_q == I_OFF);
  COV_EXPIRE: cover property (io_any ##1 !io_any);
  COV_USER_ON: cover property (user_r);
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the lamp blink-code controller
// Assumes: one ms tick per clock so that blink codes stay short
// Notes: codes are decoded from lamp on and off widths, not exact edges
`timescale 1ns/1ns
module tb;
  import lbc_pkg::*;
  localparam int unsigned TK = 1;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  lbc_bus_req_t bus = '0;
  logic [31:0] rdata_o;
  lbc_mode_t mode = MODE_OFF;
  logic ld = 1'b0;
  logic run = 1'b0;
  lbc_int_fault_t ifl = '0;
  logic [NCH-1:0] ana = '0;
  lbc_io_fault_t iof = '0;
  logic uval = 1'b0;
  lbc_lamps_t lamps_o;
  logic [NCH-1:0] ana_lowlow_o;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #4 clk_i = ~clk_i;

  lbc_lamp_ctrl #(.TICK_CYC(TK)) i_lbc_lamp_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata_o),
    .mode_i(mode), .prog_loaded_i(ld), .prog_run_i(run),
    .int_fault_i(ifl), .ana_diag_i(ana), .io_fault_i(iof),
    .user_val_i(uval), .lamps_o(lamps_o), .ana_lowlow_o(ana_lowlow_o));

  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus <= '0;
  endtask

  // data is taken in the single cycle after the read strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    bus <= '0;
    #1 d = rdata_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string msg);
    logic [31:0] d;
    rreg(a, d);
    chk(d === e, msg);
  endtask

  task automatic io_ev(input logic [2:0] k, input logic [3:0] c);
    @(posedge clk_i);
    iof <= '{valid: 1'b1, kind: k, chan: c};
    @(posedge clk_i);
    iof <= '0;
  endtask

  task automatic int_ev(input logic [3:0] c);
    @(posedge clk_i);
    ifl <= '{valid: 1'b1, code: c};
    @(posedge clk_i);
    ifl <= '0;
  endtask

  task automatic set_mode(input lbc_mode_t m);
    @(posedge clk_i);
    mode <= m;
    cyc(4);
  endtask

  function automatic logic lamp(input int sel);
    case (sel)
      0: return lamps_o.int_fault;
      1: return lamps_o.io_fault;
      2: return lamps_o.status;
      default: return lamps_o.user;
    endcase
  endfunction

  function automatic int exp_short(input logic [2:0] k);
    return int'(k);
  endfunction

  function automatic int exp_long(input logic [3:0] c);
    return int'(c) + 1;
  endfunction

  task automatic span(input int sel, input logic v, input int lim,
                      output int w);
    w = 0;
    while (lamp(sel) === v && w < lim) begin
      @(posedge clk_i);
      w++;
    end
  endtask

  task automatic watch(input int sel, input int n, output int ones,
                       output int tg);
    logic p;
    ones = 0;
    tg = 0;
    p = lamp(sel);
    repeat (n) begin
      @(posedge clk_i);
      ones += int'(lamp(sel) === 1'b1);
      tg += int'(lamp(sel) !== p);
      p = lamp(sel);
    end
  endtask

  // a dark spell over 1600 ms ends a code; the mid pause is shorter
  task automatic grab(input int sel, output int ns, output int nl,
                      output bit ordok);
    int w;
    ns = 0;
    nl = 0;
    ordok = 1'b1;
    span(sel, 1'b0, 30000 * TK, w);
    chk(w < 30000 * TK, "no blink code seen");
    do begin
      span(sel, 1'b1, 1000 * TK, w);
      if (w < 400 * TK) begin
        ns++;
        ordok &= (nl == 0);
      end else begin
        nl++;
      end
      span(sel, 1'b0, 1600 * TK, w);
    end while (w < 1600 * TK && ns + nl < 40);
  endtask

  // a latch write alone leaves the running timer alone, so a fresh
  // fault reloads it with the short time and everything expires
  task automatic clear_faults();
    logic [31:0] d;
    wreg(REG_LATCH, 32'h1);
    io_ev(3'h1, 4'h0);
    cyc(20 * TK);
    rreg(REG_STAT, d);
    chk(d[1:0] === 2'b00, "faults still latched");
    chk(lamps_o.io_fault === 1'b0, "I/O lamp lit without fault");
    wreg(REG_LATCH, 32'hffff);
  endtask

  initial begin
    int ns;
    int nl;
    int a;
    int b;
    bit ok;
    logic [31:0] d;
    logic [3:0] cd;
    logic [NCH-1:0] m;
    logic [2:0] kd [5] = '{3'h2, 3'h1, 3'h3, 3'h4, 3'h5};
    lbc_mode_t gm [9] = '{MODE_OFF, MODE_OPER, MODE_OPER, MODE_VERIFY,
      MODE_VERIFY, MODE_OPER, MODE_DOWNLOAD, MODE_FAILSAFE, MODE_UPGRADE};
    logic [1:0] glr [9] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0,
      2'h2, 2'h2};
    int ge [9] = '{0, 1, 2, 2, 2, 2, 2, 2, 2};
    void'($urandom(32'hac6e601a));
    cyc(16);
    rst_i <= 1'b0;
    #1 chk(lamps_o === '0 && rdata_o === 32'h0, "not idle");
    rchk(REG_CTRL, 32'h0, "CTRL reset");
    rchk(REG_UPER, {16'h0, UPER_RST}, "UPER reset");
    rchk(REG_LATCH, {16'h0, LATCH_RST}, "LATCH reset");
    @(posedge clk_i);
    #1 chk(rdata_o === 32'h0, "read data held too long");
    d = $urandom;
    wreg(REG_UPER, d);
    rchk(REG_UPER, {16'h0, d[15:0]}, "UPER readback");
    wreg(REG_STAT, 32'hffffffff);
    wreg(8'h10, d);
    rchk(REG_STAT, 32'h0, "STAT took a write");
    rchk(8'h10, 32'h0, "unmapped read");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      mode <= gm[i];
      {ld, run} <= glr[i];
      cyc(4);
      watch(2, 600 * TK, ns, nl);
      chk(ge[i] != 0 || ns == 0, "status lit when off");
      chk(ge[i] != 1 || ns == 600 * TK, "status not steady");
      chk(ge[i] != 2 || nl >= 2, "status not flashing");
    end
    @(posedge clk_i);
    uval <= 1'b1;
    watch(3, 50, ns, nl);
    chk(ns == 0, "user lamp lit while disabled");
    wreg(REG_CTRL, 32'h1);
    wreg(REG_UPER, 32'h1);
    cyc(4);
    watch(3, 50, ns, nl);
    chk(ns == 50, "user lamp not following value");
    @(posedge clk_i);
    uval <= 1'b0;
    cyc(4);
    watch(3, 50, ns, nl);
    chk(ns == 0, "user lamp lit with value low");
    @(posedge clk_i);
    uval <= 1'b1;
    wreg(REG_UPER, 32'h14);
    cyc(30 * TK);
    watch(3, 200 * TK, ns, nl);
    chk(nl >= 18 && nl <= 21, "user flash period");
    set_mode(MODE_OPER);
    wreg(REG_LATCH, 32'h28);
    io_ev(3'h1, 4'h0);
    cyc(30 * TK);
    rreg(REG_STAT, d);
    chk(d[0] === 1'b1, "fault dropped early");
    cyc(20 * TK);
    rreg(REG_STAT, d);
    chk(d[0] === 1'b0, "fault outlived latch time");
    wreg(REG_LATCH, 32'hffff);
    for (int k = 6; k < 9; k++)
      io_ev(3'(k), 4'h3);
    rreg(REG_STAT, d);
    chk(d[0] === 1'b0, "unknown fault kind latched");
    for (int i = 0; i < 5; i++) begin
      cd = (i == 0) ? 4'h2 : 4'($urandom_range(1, 0));
      io_ev(kd[i], cd);
      grab(1, ns, nl, ok);
      ok &= ns == exp_short(kd[i]) && nl == exp_long(cd);
      chk(ok, "io code");
      rreg(REG_STAT, d);
      chk(d[10:8] === kd[i] && d[15:12] === cd, "io status");
      if (i == 0) begin
        grab(1, ns, nl, ok);
        chk(ns == 2 && nl == 3, "I/O code not repeated");
      end
      clear_faults();
    end
    io_ev(3'h3, 4'h1);
    io_ev(3'h1, 4'h0);
    grab(1, ns, nl, ok);
    a = ns * 16 + nl;
    grab(1, ns, nl, ok);
    b = ns * 16 + nl;
    grab(1, ns, nl, ok);
    chk(a != b && a + b == 67 && ns * 16 + nl == a, "fault cycle");
    clear_faults();
    for (int i = 1; i < 5; i++) begin
      set_mode(MODE_OFF);
      set_mode(MODE_OPER);
      cd = (i < 4) ? 4'(i) : 4'($urandom_range(9, 4));
      int_ev(4'h1);
      int_ev(4'h0);
      int_ev(cd);
      watch(0, 100, ns, nl);
      chk(ns == 0, "internal lamp lit outside shutdown");
      set_mode(MODE_FAILSAFE);
      grab(0, ns, nl, ok);
      chk(ns == int'(cd) && nl == 0, "internal code wrong");
      rreg(REG_STAT, d);
      chk(d[7:4] === cd && d[2] === 1'b1, "internal status");
    end
    set_mode(MODE_OFF);
    set_mode(MODE_OPER);
    m = 16'($urandom) | 16'h1;
    @(posedge clk_i);
    ana <= m;
    @(posedge clk_i);
    ana <= '0;
    cyc(2);
    chk(ana_lowlow_o === m, "analog channels not forced low");
    grab(0, ns, nl, ok);
    chk(ns == 4 && nl == 0, "analog diagnostic code wrong");
    clear_faults();
    chk(ana_lowlow_o === '0, "analog force not released");
    complete_run();
  end

  // full sequence needs roughly 68k cycles
  initial begin
    cyc(95000);
    n_mismatch++;
    complete_run();
  end
endmodule
